/* File: verilog/reset_ctl_pkg.sv */
// Purpose: shared constants and types for the module reset controller
// Assumes: 200 MHz system clock, one clock domain
// Notes:   pad control words describe drive and weak pulls for each pin
package reset_ctl_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 5;
  localparam int TICK_NS        = 1000;  // one timing tick per microsecond
  localparam int TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W         = 8;
  localparam int HOLD_US        = 10;    // reset stretch after last source lets go
  localparam int HOLD_TICKS     = HOLD_US * 1000 / TICK_NS;
  localparam int XIN_IDLE_US    = 50;    // no crystal edge for this long means no clock
  localparam int XIN_IDLE_TICKS = XIN_IDLE_US * 1000 / TICK_NS;

  // ---------------------------------------------------------------
  // field widths and reset values
  // ---------------------------------------------------------------
  localparam int CNT_W           = 16;
  localparam int BAUD_W          = 16;
  localparam int FREQ_W          = 16;
  localparam int NUM_PROG        = 12;
  localparam int NUM_ANA         = 3;
  localparam int ANA_DRIVEN_IDX  = 1;
  localparam logic [BAUD_W-1:0] BAUD_DEFAULT  = 16'h01d8;
  localparam logic [FREQ_W-1:0] XTAL_MAX_KHZ  = 16'h7d00;  // highest supported crystal
  localparam logic [CNT_W-1:0]  BREAK_KEY_DEF = 16'h0400;

  // ---------------------------------------------------------------
  // pad control types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic oe;         // high while the pad drives
    logic out;
    logic pull_up;
    logic pull_down;
  } pad_ctl_s;

  typedef struct packed {
    pad_ctl_s [NUM_PROG-1:0] prog;
    pad_ctl_s [NUM_ANA-1:0]  ana;
    pad_ctl_s                ser_tx;
    pad_ctl_s                ser_rts;
    pad_ctl_s                ser_rx;
    pad_ctl_s                ser_cts;
    pad_ctl_s                cfg_sel;
    pad_ctl_s                cfg_clk;
    pad_ctl_s                cfg_din;
    pad_ctl_s                cfg_dout;
  } pads_s;

  localparam pad_ctl_s PAD_IN_PD  = '{oe: 1'b0, out: 1'b0, pull_up: 1'b0, pull_down: 1'b1};
  localparam pad_ctl_s PAD_IN_PU  = '{oe: 1'b0, out: 1'b0, pull_up: 1'b1, pull_down: 1'b0};
  localparam pad_ctl_s PAD_HIZ    = '{oe: 1'b0, out: 1'b0, pull_up: 1'b0, pull_down: 1'b0};
  localparam pad_ctl_s PAD_DRV_LO = '{oe: 1'b1, out: 1'b0, pull_up: 1'b0, pull_down: 1'b0};

  // safe pad state held for the whole of reset
  localparam pads_s PADS_RESET = '{
    prog:     {NUM_PROG{PAD_IN_PD}},
    ana:      {PAD_HIZ, PAD_DRV_LO, PAD_HIZ},
    ser_tx:   PAD_IN_PU,
    ser_rts:  PAD_IN_PU,
    ser_rx:   PAD_IN_PD,
    ser_cts:  PAD_IN_PD,
    cfg_sel:  PAD_IN_PU,
    cfg_clk:  PAD_IN_PD,
    cfg_din:  PAD_IN_PD,
    cfg_dout: PAD_IN_PD
  };

  // ---------------------------------------------------------------
  // module state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CAUSE_POWER,
    CAUSE_BREAK,
    CAUSE_WATCHDOG,
    CAUSE_FAULT
  } reset_cause_e;

  typedef struct packed {
    logic [1:0]       sync;
    logic [CNT_W-1:0] cnt;
    logic             brk;
  } break_state_s;

endpackage

/* File: verilog/break_detect.sv */
// Purpose: detect a break (serial receive held low) longer than a timeout
// Assumes: i_tick is a one-cycle pulse from the tick divider
// Notes:   runs during reset too, so a held break keeps the device in reset
`timescale 1ns/10ps
module break_detect (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  // timing and configuration
  input  wire logic                       i_tick,
  input  wire logic [reset_ctl_pkg::CNT_W-1:0] i_timeout,
  // serial receive pin, asynchronous
  input  wire logic                       i_serial_rx,
  // result
  output logic                            o_break
);
  import reset_ctl_pkg::*;

  break_state_s state;
  break_state_s next_state;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // counter saturates so a break of any length stays detected
  always_comb begin
    next_state      = state;
    next_state.sync = {state.sync[0], i_serial_rx};
    if (state.sync[1]) begin
      next_state.cnt = '0;
    end else if (i_tick && (state.cnt != {CNT_W{1'b1}})) begin
      next_state.cnt = state.cnt + 16'h0001;
    end
    next_state.brk = (!state.sync[1]) && (state.cnt > i_timeout);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '{sync: 2'b11, cnt: '0, brk: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign o_break = state.brk;

endmodule // break_detect

/* File: verilog/module_reset_control.sv */
// Purpose: reset gathering, safe pad states and clock safety for the radio module
// Assumes: i_reset_n is the power-on reset; software settings arrive as plain inputs
// Notes:   warm resets keep baud rate and RAM, cold resets restore defaults
`timescale 1ns/10ps

// What this block does
// - reset comes from power-on, a serial break, watchdog expiry, or a firmware fault request.
// - a receive-line low longer than the break timeout key causes reset.
// - in reset, two-way pins are inputs and output-only pins float.
// - in reset, every programmable pin has its weak pull-down on.
// - in reset, transmit and rts float pulled up; receive and cts pulled down.
// - in reset, select pulled up; clock, data-in pulled down; data-out floats pulled down.
// - in reset, programmable pins 6..2 pulled-down inputs; analogue pin 1 drives low.
// - after any reset assume the highest crystal frequency until software sets it.
// - with no crystal clock the oscillator free-runs at a safe rate.
// - warm reset keeps the configured baud rate and working RAM.
// - cold reset loses baud rate and RAM; defaults come back.
// - power cycle or firmware-fault system reset counts as cold.
module module_reset_control #(
  parameter int TICK_CYCLES_P = reset_ctl_pkg::TICK_CYCLES,
  parameter int HOLD_TICKS_P  = reset_ctl_pkg::HOLD_TICKS,
  parameter int XIN_IDLE_P    = reset_ctl_pkg::XIN_IDLE_TICKS
) (
  // clock and power-on reset
  input  wire logic                                i_clk,
  input  wire logic                                i_reset_n,
  // break detection
  input  wire logic                                i_serial_rx,
  input  wire logic [reset_ctl_pkg::CNT_W-1:0]     i_break_reset_timeout_key,
  // watchdog, set by software
  input  wire logic                                i_wdog_enable,
  input  wire logic [reset_ctl_pkg::CNT_W-1:0]     i_wdog_timeout,
  input  wire logic                                i_wdog_kick,
  // firmware fault system reset request
  input  wire logic                                i_fault_reset,
  // software settings
  input  wire logic                                i_baud_load,
  input  wire logic [reset_ctl_pkg::BAUD_W-1:0]    i_baud_value,
  input  wire logic                                i_ram_init_done,
  input  wire logic                                i_xtal_set,
  input  wire logic [reset_ctl_pkg::FREQ_W-1:0]    i_xtal_khz,
  // crystal pin, asynchronous
  input  wire logic                                i_crystal_input,
  // functional pad requests outside reset
  input  wire reset_ctl_pkg::pads_s                i_func_pads,
  // reset and status outputs
  output logic                                     o_active_low_reset,
  output logic                                     o_cold_reset,
  output reset_ctl_pkg::reset_cause_e              o_reset_cause,
  output logic [reset_ctl_pkg::BAUD_W-1:0]         o_baud_rate,
  output logic                                     o_ram_valid,
  output logic [reset_ctl_pkg::FREQ_W-1:0]         o_xtal_khz,
  output logic                                     o_osc_free_run,
  // pad controls
  output reset_ctl_pkg::pads_s                     o_pads
);
  import reset_ctl_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);
  localparam logic [CNT_W-1:0]  HOLD_LOAD = CNT_W'(HOLD_TICKS_P);
  localparam logic [CNT_W-1:0]  XIN_LIM   = CNT_W'(XIN_IDLE_P);

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic              in_reset;
    logic [CNT_W-1:0]  hold_cnt;
    logic [CNT_W-1:0]  wd_cnt;
    reset_cause_e      cause;
    logic              cold;
    logic [BAUD_W-1:0] baud;
    logic              ram_valid;
    logic [1:0]        xin_sync;
    logic              xin_prev;
    logic [2:0]        xin_fill;
    logic [CNT_W-1:0]  xin_idle;
    logic              free_run;
    logic [FREQ_W-1:0] xtal_khz;
    pads_s             pads;
  } top_state_s;

  top_state_s state;
  top_state_s next_state;
  logic       tick;
  logic       brk;
  logic       wd_expire;
  logic       xin_edge;

  // ---------------------------------------------------------------
  // break detector
  // ---------------------------------------------------------------
  break_detect u_break_detect (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_tick      (tick),
    .i_timeout   (i_break_reset_timeout_key),
    .i_serial_rx (i_serial_rx),
    .o_break     (brk)
  );

  // ---------------------------------------------------------------
  // derived strobes
  // ---------------------------------------------------------------
  assign tick      = (state.tick_cnt == TICK_LAST);
  // watchdog is only armed outside reset, so it cannot retrigger itself
  assign wd_expire = i_wdog_enable && !state.in_reset && (state.wd_cnt >= i_wdog_timeout);
  // edges count only once the pin level has filled both stages and the last-value flop,
  // so a pin idling high after reset does not fake crystal activity
  assign xin_edge  = state.xin_fill[2] && (state.xin_sync[1] ^ state.xin_prev);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state          = state;
    next_state.tick_cnt = tick ? '0 : state.tick_cnt + 8'h01;

    // watchdog counter
    if (state.in_reset || !i_wdog_enable || i_wdog_kick) begin
      next_state.wd_cnt = '0;
    end else if (tick && (state.wd_cnt != {CNT_W{1'b1}})) begin
      next_state.wd_cnt = state.wd_cnt + 16'h0001;
    end

    // gather sources; a break still held keeps the stretch reloaded
    if (brk || wd_expire || i_fault_reset) begin
      next_state.in_reset = 1'b1;
      next_state.hold_cnt = HOLD_LOAD;
    end else if (state.hold_cnt != '0) begin
      if (tick) begin
        next_state.hold_cnt = state.hold_cnt - 16'h0001;
      end
    end else begin
      next_state.in_reset = 1'b0;
    end

    // cause and warm/cold class; a fault outranks other sources
    if (i_fault_reset) begin
      next_state.cause = CAUSE_FAULT;
      next_state.cold  = 1'b1;
    end else if (wd_expire) begin
      next_state.cause = CAUSE_WATCHDOG;
      next_state.cold  = 1'b0;
    end else if (brk && !state.in_reset) begin
      next_state.cause = CAUSE_BREAK;
      next_state.cold  = 1'b0;
    end

    // baud and RAM survive warm reset, reload on cold
    if (i_fault_reset) begin
      next_state.baud      = BAUD_DEFAULT;
      next_state.ram_valid = 1'b0;
    end else if (!state.in_reset) begin
      if (i_baud_load) begin
        next_state.baud = i_baud_value;
      end
      if (i_ram_init_done) begin
        next_state.ram_valid = 1'b1;
      end
    end

    // crystal activity monitor
    next_state.xin_sync = {state.xin_sync[0], i_crystal_input};
    next_state.xin_prev = state.xin_sync[1];
    next_state.xin_fill = {state.xin_fill[1:0], 1'b1};
    if (xin_edge) begin
      next_state.xin_idle = '0;
    end else if (tick && (state.xin_idle != XIN_LIM)) begin
      next_state.xin_idle = state.xin_idle + 16'h0001;
    end
    next_state.free_run = (next_state.xin_idle == XIN_LIM);

    // crystal frequency falls back to maximum in any reset
    if (next_state.in_reset) begin
      next_state.xtal_khz = XTAL_MAX_KHZ;
    end else if (i_xtal_set) begin
      next_state.xtal_khz = i_xtal_khz;
    end

    // pads follow reset with no cycle of functional drive in between
    if (next_state.in_reset) begin
      next_state.pads = PADS_RESET;
    end else begin
      next_state.pads = i_func_pads;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // power-on is a cold reset: everything takes its default constant
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state.tick_cnt  <= '0;
      state.in_reset  <= 1'b1;
      state.hold_cnt  <= HOLD_LOAD;
      state.wd_cnt    <= '0;
      state.cause     <= CAUSE_POWER;
      state.cold      <= 1'b1;
      state.baud      <= BAUD_DEFAULT;
      state.ram_valid <= 1'b0;
      state.xin_sync  <= 2'b00;
      state.xin_prev  <= 1'b0;
      state.xin_fill  <= 3'h0;
      state.xin_idle  <= XIN_LIM;
      state.free_run  <= 1'b1;
      state.xtal_khz  <= XTAL_MAX_KHZ;
      state.pads      <= PADS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_active_low_reset = !state.in_reset;
  assign o_cold_reset       = state.cold;
  assign o_reset_cause      = state.cause;
  assign o_baud_rate        = state.baud;
  assign o_ram_valid        = state.ram_valid;
  assign o_xtal_khz         = state.xtal_khz;
  assign o_osc_free_run     = state.free_run;
  assign o_pads             = state.pads;

endmodule // module_reset_control

/* File: sim/module_reset_control_checker.sv */
// Purpose: concurrent checks on the reset controller ports
// Assumes: one clock, asynchronous active-low power-on reset
// Notes:   the break bound allows for the 2FF sync and tick phase
`timescale 1ns/10ps
module module_reset_control_checker
  import reset_ctl_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int XIN_IDLE_P    = XIN_IDLE_TICKS
) (
  input wire logic             i_clk,
  input wire logic             i_reset_n,
  input wire logic             i_serial_rx,
  input wire logic [CNT_W-1:0] i_break_reset_timeout_key,
  input wire logic             i_fault_reset,
  input wire logic             i_crystal_input,
  input wire logic             o_active_low_reset,
  input wire logic             o_cold_reset,
  input wire reset_cause_e     o_reset_cause,
  input wire logic [BAUD_W-1:0] o_baud_rate,
  input wire logic             o_ram_valid,
  input wire logic [FREQ_W-1:0] o_xtal_khz,
  input wire logic             o_osc_free_run,
  input wire pads_s            o_pads
);
  // ---------------------------------------------------------------
  // helper and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  int low_cnt;
  logic xin_q;
  int   xin_stable;
  // cycles the receive line has been low; no saturation, runs are short
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) low_cnt <= 0;
    else low_cnt <= i_serial_rx ? 0 : low_cnt + 1;
  // cycles the crystal pin has held one level; a high level after reset counts as a change
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) begin
      xin_q      <= 1'b0;
      xin_stable <= 0;
    end else begin
      xin_q      <= i_crystal_input;
      xin_stable <= (i_crystal_input != xin_q) ? 0 : xin_stable + 1;
    end
  property p_pads; !o_active_low_reset |-> o_pads == PADS_RESET; endproperty
  a_pads: assert property (p_pads) else $error("pads not safe in reset");
  property p_prog; !o_active_low_reset |-> o_pads.prog == {NUM_PROG{PAD_IN_PD}}; endproperty
  a_prog: assert property (p_prog) else $error("prog pulls wrong");
  property p_ser;
    !o_active_low_reset |-> !o_pads.ser_tx.oe && o_pads.ser_tx.pull_up && o_pads.ser_rx.pull_down;
  endproperty
  a_ser: assert property (p_ser) else $error("serial pads wrong");
  property p_ana; !o_active_low_reset |-> o_pads.ana[ANA_DRIVEN_IDX] == PAD_DRV_LO; endproperty
  a_ana: assert property (p_ana) else $error("analogue pin not low");
  property p_xtal; !o_active_low_reset |-> o_xtal_khz == XTAL_MAX_KHZ; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal not max");
  property p_fault;
    o_active_low_reset && i_fault_reset |=>
      !o_active_low_reset && o_cold_reset && o_reset_cause == CAUSE_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("fault reset wrong");
  property p_cold;
    !o_active_low_reset && o_cold_reset |-> o_baud_rate == BAUD_DEFAULT && !o_ram_valid;
  endproperty
  a_cold: assert property (p_cold) else $error("cold defaults wrong");
  property p_warm;
    $fell(o_active_low_reset) && !o_cold_reset |-> $stable(o_baud_rate) && $stable(o_ram_valid);
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset lost state");
  property p_brk;
    low_cnt > (int'(i_break_reset_timeout_key) + 2) * TICK_CYCLES_P + 4 |-> !o_active_low_reset;
  endproperty
  a_brk: assert property (p_brk) else $error("break did not reset");
  property p_release;
    $rose(o_active_low_reset) |-> !$past(i_fault_reset) &&
      low_cnt <= (int'(i_break_reset_timeout_key) + 2) * TICK_CYCLES_P + 4;
  endproperty
  a_release: assert property (p_release) else $error("released with source on");
  property p_osc;
    xin_stable > (XIN_IDLE_P + 1) * TICK_CYCLES_P + 4 |-> o_osc_free_run;
  endproperty
  a_osc: assert property (p_osc) else $error("no free run");
  c_fault: cover property (!o_active_low_reset && o_reset_cause == CAUSE_FAULT);
  c_break: cover property (!o_active_low_reset && o_reset_cause == CAUSE_BREAK);
  c_wdog: cover property (!o_active_low_reset && o_reset_cause == CAUSE_WATCHDOG);
endmodule // module_reset_control_checker

bind module_reset_control module_reset_control_checker #(.TICK_CYCLES_P(TICK_CYCLES_P),
  .XIN_IDLE_P(XIN_IDLE_P))
  i_checker (.i_clk, .i_reset_n, .i_serial_rx, .i_break_reset_timeout_key, .i_fault_reset,
  .i_crystal_input, .o_active_low_reset, .o_cold_reset, .o_reset_cause, .o_baud_rate,
  .o_ram_valid, .o_xtal_khz, .o_osc_free_run, .o_pads);

/* File: sim/host_link_model.sv */
// Purpose: host end of the serial link, idle mark or break
// Assumes: bench asks for a break long enough when it wants a reset
// Notes:   the line is always driven, so the rx pull-down never decides it
`timescale 1ns/10ps
module host_link_model (
  input  wire logic i_clk,
  input  wire logic i_break_req,
  output logic      o_serial_rx
);
  // the bench moves the request on the falling edge, so the line follows it there;
  // a break is a plain held low
  always_comb o_serial_rx = !i_break_req;
endmodule // host_link_model

/* File: sim/module_reset_control_bench.sv */
// Purpose: self-checking bench for the reset controller
// Assumes: short tick, hold and idle params for quick runs
// Notes:   expected state kept in a small reference model below
`timescale 1ns/10ps
module module_reset_control_bench;
  import reset_ctl_pkg::*;
  logic i_clk, i_reset_n, brk_req, rx, wd_en, wd_kick, fault, b_ld, r_done, x_set, xin, rst_o;
  logic [15:0] key, wd_to, b_val, x_val, e_baud, e_xtal, baud, xk;
  logic e_ram, e_cold, cold, ram, frun;
  reset_cause_e e_cause, cause;
  pads_s f_pads, pads;
  int fail_count, comparisons;
  host_link_model i_host_link_model (.i_clk(i_clk), .i_break_req(brk_req), .o_serial_rx(rx));
  module_reset_control #(.TICK_CYCLES_P(2), .HOLD_TICKS_P(2), .XIN_IDLE_P(3))
  i_module_reset_control (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_serial_rx(rx),
    .i_break_reset_timeout_key(key), .i_wdog_enable(wd_en), .i_wdog_timeout(wd_to),
    .i_wdog_kick(wd_kick), .i_fault_reset(fault), .i_baud_load(b_ld), .i_baud_value(b_val),
    .i_ram_init_done(r_done), .i_xtal_set(x_set), .i_xtal_khz(x_val), .i_crystal_input(xin),
    .i_func_pads(f_pads), .o_active_low_reset(rst_o), .o_cold_reset(cold),
    .o_reset_cause(cause), .o_baud_rate(baud), .o_ram_valid(ram), .o_xtal_khz(xk),
    .o_osc_free_run(frun), .o_pads(pads));
  always #2.5 i_clk = ~i_clk;
  // ---------------------------------------------------------------
  // checking tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait; a missing edge shows up as a mismatch, not a hang
  task automatic wait_rst(input logic v);
    for (int n = 0; n < 200 && rst_o !== v; n++) @(negedge i_clk);
    chk(rst_o, v);
  endtask
  task automatic status();
    chk(baud, e_baud);
    chk(ram, e_ram);
    chk({cold, cause}, {e_cold, e_cause});
    chk(xk, e_xtal);
  endtask
  task automatic in_reset(input reset_cause_e c, input logic cl);
    wait_rst(1'b0);
    e_cause = c;
    e_cold = cl;
    e_xtal = XTAL_MAX_KHZ;
    if (cl) begin
      e_baud = BAUD_DEFAULT;
      e_ram = 1'b0;
    end
    status();
    chk(pads, PADS_RESET);
  endtask
  task automatic released();
    wait_rst(1'b1);
    @(negedge i_clk);
    chk(pads, f_pads);
    status();
  endtask
  // loads are pulses; model takes the values the bench sent
  task automatic configure();
    b_val = 16'($urandom);
    x_val = 16'($urandom);
    {b_ld, r_done, x_set} = 3'h7;
    @(negedge i_clk);
    {b_ld, r_done, x_set} = 3'h0;
    {e_baud, e_ram, e_xtal} = {b_val, 1'b1, x_val};
    @(negedge i_clk);
    status();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {i_clk, i_reset_n, brk_req, wd_en, wd_kick, fault, b_ld, r_done, x_set, xin} = '0;
    {fail_count, comparisons, b_val, x_val} = '0;
    void'($urandom(32'h8e3c526b));
    f_pads = pads_s'(92'({$urandom, $urandom, $urandom}));
    key = 16'h0003 + 16'($urandom_range(3));
    wd_to = 16'h0005;
    {e_baud, e_ram, e_xtal, e_cold} = {BAUD_DEFAULT, 1'b0, XTAL_MAX_KHZ, 1'b1};
    e_cause = CAUSE_POWER;
    repeat (2) @(negedge i_clk);
    in_reset(CAUSE_POWER, 1'b1);
    i_reset_n = 1'b1;
    released();
    configure();
    // kicks inside the timeout keep the device running
    wd_en = 1'b1;
    repeat (20) begin
      wd_kick = 1'b1;
      @(negedge i_clk);
      wd_kick = 1'b0;
      @(negedge i_clk);
    end
    chk(rst_o, 1'b1);
    in_reset(CAUSE_WATCHDOG, 1'b0);
    wd_en = 1'b0;
    released();
    configure();
    // a low no longer than the key must not reset
    brk_req = 1'b1;
    repeat (2 * key) @(negedge i_clk);
    brk_req = 1'b0;
    repeat (8) @(negedge i_clk);
    chk(rst_o, 1'b1);
    brk_req = 1'b1;
    in_reset(CAUSE_BREAK, 1'b0);
    repeat (50) @(negedge i_clk);
    chk(rst_o, 1'b0);
    brk_req = 1'b0;
    released();
    configure();
    fault = 1'b1;
    @(negedge i_clk);
    fault = 1'b0;
    in_reset(CAUSE_FAULT, 1'b1);
    released();
    repeat (20) begin
      xin = !xin;
      @(negedge i_clk);
    end
    chk(frun, 1'b0);
    repeat (20) @(negedge i_clk);
    chk(frun, 1'b1);
    // a power cycle in mid-run is cold: what software set must be gone
    configure();
    i_reset_n = 1'b0;
    @(negedge i_clk);
    in_reset(CAUSE_POWER, 1'b1);
    i_reset_n = 1'b1;
    released();
    end_of_test();
  end
  // the scenarios need about 220 cycles; far past that is a hang
  initial begin
    #50000;
    fail_count++;
    end_of_test();
  end
endmodule // module_reset_control_bench
